/* File: rtl/ims_pkg.sv */
package ims_pkg;
	// Register byte addresses on the Avalon-MM slave
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TEN = 8'h04;
	localparam logic [7:0] ADDR_TFLAG = 8'h08;
	localparam logic [7:0] ADDR_TSET = 8'h0C;
	localparam logic [7:0] ADDR_GFLAG = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam logic [7:0] ADDR_MASK = 8'h18;

	// Field positions in the control register
	localparam int CTRL_GIE_BIT = 0;
	localparam int CTRL_GEN_LSB = 1;
	localparam int CTRL_DEPTH_LSB = 4;

	// Timer request flags: two per timer, A match even, P match odd
	localparam int NUM_FLAGS = 10;
	localparam logic [9:0] FLAGS_CT0 = 10'h003;
	localparam logic [9:0] FLAGS_GRP0 = 10'h03C;
	localparam logic [9:0] FLAGS_GRP1 = 10'h0C0;
	localparam logic [9:0] FLAGS_PTM = 10'h300;

	// Return stack, counted here so a full stack can block vectoring
	localparam logic [3:0] STACK_DEPTH = 4'h8;
	localparam logic [3:0] DEPTH_ONE = 4'h1;

	// Status bit positions
	localparam int STAT_VEC = 0;
	localparam int STAT_WAKE = 1;

	// Vector identifiers, lower value wins on a tie
	typedef enum logic [1:0] {
		VEC_CT0,
		VEC_PTM,
		VEC_GRP0,
		VEC_GRP1
	} ims_vec_t;

	// Strobes and levels from the processor core, all on sys_clk
	typedef struct packed {
		logic insn_boundary;
		logic call_push;
		logic intr_exit;
		logic sub_exit;
		logic sleep_idle;
	} ims_core_t;

	// State of the sequencer except the timer flags, which the flag cells hold
	typedef struct packed {
		logic gie;
		logic [1:0] gen;
		logic [9:0] ten;
		logic [1:0] gflag;
		logic [1:0] gflag_prev;
		logic [3:0] depth;
		logic vec_call;
		ims_vec_t vec_id;
		logic wake;
		logic [1:0] stat;
		logic [1:0] mask;
		logic rd_ack;
		logic [31:0] rdata;
	} ims_state_t;

	localparam ims_state_t STATE_RESET = '0;

	// State of one sticky request flag
	typedef struct packed {
		logic flag;
		logic prev;
	} ims_flag_t;
endpackage : ims_pkg

/* File: rtl/ims_flag_cell.sv */
`timescale 1ns/100ps
module ims_flag_cell (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic set_pulse,
	input wire logic clr_pulse,
	output logic flag,
	output logic rise
);
	ims_pkg::ims_flag_t s_reg;
	ims_pkg::ims_flag_t s_next;

	// Sticky flag; a set in the clearing cycle wins so no event is lost
	always_comb begin
		s_next.flag = set_pulse | (s_reg.flag & ~clr_pulse);
		s_next.prev = s_reg.flag;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign flag = s_reg.flag;
	// Low-to-high edge, seen in the first cycle the flag is high
	assign rise = s_reg.flag & ~s_reg.prev;
endmodule : ims_flag_cell

/* File: rtl/ims_sequencer.sv */
`timescale 1ns/100ps
module ims_sequencer (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [4:0] tm_match_a,
	input wire logic [4:0] tm_match_p,
	input wire ims_pkg::ims_core_t core,
	output logic vector_call,
	output ims_pkg::ims_vec_t vector_id,
	output logic wake_up,
	output logic stack_full,
	output logic irq
);
	ims_pkg::ims_state_t s_reg;
	ims_pkg::ims_state_t s_next;
	logic [9:0] flags;
	logic [9:0] rises;
	logic [9:0] flag_set;
	logic [9:0] flag_clr;
	logic [9:0] req;
	logic [1:0] grp_rise;
	logic [1:0] gflag_clr;
	logic pend_ct0;
	logic pend_ptm;
	logic pend_g0;
	logic pend_g1;
	logic vec_take;
	logic full;

	genvar gi;
	generate
		for (gi = 0; gi < ims_pkg::NUM_FLAGS; gi++) begin : g_flag
			logic match;
			assign match = (gi % 2 == 1) ? tm_match_p[gi / 2]
				: tm_match_a[gi / 2];
			ims_flag_cell u_cell (
				.sys_clk(sys_clk),
				.reset_n(reset_n),
				.set_pulse(match | flag_set[gi]),
				.clr_pulse(flag_clr[gi]),
				.flag(flags[gi]),
				.rise(rises[gi])
			);
		end
	endgenerate

	// a timer requests when either enabled flag is set
	assign req = flags & s_reg.ten;
	assign full = (s_reg.depth == ims_pkg::STACK_DEPTH);

	// own vectors for timer zero and the periodic timer
	assign pend_ct0 = |(req & ims_pkg::FLAGS_CT0);
	assign pend_ptm = |(req & ims_pkg::FLAGS_PTM);
	// grouped timers also need their group enable
	assign pend_g0 = s_reg.gflag[0] & s_reg.gen[0]
		& |(req & ims_pkg::FLAGS_GRP0);
	assign pend_g1 = s_reg.gflag[1] & s_reg.gen[1]
		& |(req & ims_pkg::FLAGS_GRP1);

	// two groups fed only by timers one to three
	assign grp_rise[0] = |(rises & ims_pkg::FLAGS_GRP0);
	assign grp_rise[1] = |(rises & ims_pkg::FLAGS_GRP1);

	// gate by global enable and free stack
	assign vec_take = core.insn_boundary & s_reg.gie & ~full
		& (pend_ct0 | pend_ptm | pend_g0 | pend_g1);

	// Next-state logic: bus access, vectoring, stack and wake-up
	always_comb begin
		s_next = s_reg;
		s_next.vec_call = 1'b0;
		s_next.rd_ack = 1'b0;
		flag_set = '0;
		flag_clr = '0;
		gflag_clr = '0;

		// Register writes take effect at once, writes never wait
		if (avs_write) begin
			case (avs_address)
				ims_pkg::ADDR_CTRL: begin
					s_next.gie = avs_writedata[ims_pkg::CTRL_GIE_BIT];
					s_next.gen = avs_writedata[ims_pkg::CTRL_GEN_LSB +: 2];
				end
				ims_pkg::ADDR_TEN: s_next.ten = avs_writedata[9:0];
				ims_pkg::ADDR_TFLAG: flag_clr = avs_writedata[9:0];
				// software may force a flag high
				ims_pkg::ADDR_TSET: flag_set = avs_writedata[9:0];
				ims_pkg::ADDR_GFLAG: gflag_clr = avs_writedata[1:0];
				ims_pkg::ADDR_MASK: s_next.mask = avs_writedata[1:0];
				default: ;
			endcase
		end

		// Reads take two cycles: latch data, then drop waitrequest
		if (avs_read && !s_reg.rd_ack) begin
			s_next.rd_ack = 1'b1;
			s_next.rdata = '0;
			case (avs_address)
				ims_pkg::ADDR_CTRL: begin
					s_next.rdata[ims_pkg::CTRL_GIE_BIT] = s_reg.gie;
					s_next.rdata[ims_pkg::CTRL_GEN_LSB +: 2] = s_reg.gen;
					s_next.rdata[ims_pkg::CTRL_DEPTH_LSB +: 4] = s_reg.depth;
				end
				ims_pkg::ADDR_TEN: s_next.rdata[9:0] = s_reg.ten;
				ims_pkg::ADDR_TFLAG: s_next.rdata[9:0] = flags;
				ims_pkg::ADDR_GFLAG: s_next.rdata[1:0] = s_reg.gflag;
				ims_pkg::ADDR_STAT: s_next.rdata[1:0] = s_reg.stat;
				ims_pkg::ADDR_MASK: s_next.rdata[1:0] = s_reg.mask;
				default: ;
			endcase
		end
		// Clear only what was reported, so a later event survives
		if (avs_read && s_reg.rd_ack && avs_address == ims_pkg::ADDR_STAT) begin
			s_next.stat = s_reg.stat & ~s_reg.rdata[1:0];
		end

		if (core.intr_exit) begin
			s_next.gie = 1'b1;
		end
		// subroutine exit only pops, enable untouched
		if ((core.intr_exit || core.sub_exit) && s_reg.depth != '0) begin
			s_next.depth = s_reg.depth - ims_pkg::DEPTH_ONE;
		end
		if (core.call_push && !full) begin
			s_next.depth = s_reg.depth + ims_pkg::DEPTH_ONE;
		end

		// entry pushes the program counter only
		if (vec_take) begin
			s_next.vec_call = 1'b1;
			// Stack on top of a same-cycle pop so the count stays true
			s_next.depth = s_next.depth + ims_pkg::DEPTH_ONE;
			// global enable drops on any entry
			s_next.gie = 1'b0;
			s_next.stat[ims_pkg::STAT_VEC] = 1'b1;
			if (pend_ct0) begin
				s_next.vec_id = ims_pkg::VEC_CT0;
				flag_clr = flag_clr | (req & ims_pkg::FLAGS_CT0);
			end else if (pend_ptm) begin
				s_next.vec_id = ims_pkg::VEC_PTM;
				flag_clr = flag_clr | (req & ims_pkg::FLAGS_PTM);
			end else if (pend_g0) begin
				s_next.vec_id = ims_pkg::VEC_GRP0;
				gflag_clr[0] = 1'b1;
			end else begin
				s_next.vec_id = ims_pkg::VEC_GRP1;
				gflag_clr[1] = 1'b1;
			end
		end

		// group flag sets on a member rising, set beats clear
		// member flags are not touched by the group service
		s_next.gflag = (s_reg.gflag & ~gflag_clr) | grp_rise;
		s_next.gflag_prev = s_reg.gflag;

		// any rising flag wakes the core
		s_next.wake = core.sleep_idle
			& (|rises | |(s_reg.gflag & ~s_reg.gflag_prev));
		if (s_next.wake) begin
			s_next.stat[ims_pkg::STAT_WAKE] = 1'b1;
		end
	end

	// Single state register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= ims_pkg::STATE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs, data from flops, waitrequest combinational
	assign avs_readdata = s_reg.rdata;
	assign avs_waitrequest = avs_read & ~s_reg.rd_ack;
	assign vector_call = s_reg.vec_call;
	assign vector_id = s_reg.vec_id;
	assign wake_up = s_reg.wake;
	assign stack_full = full;
	assign irq = |(s_reg.stat & s_reg.mask);

	// Checks, all on sys_clk
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	a_group_flag_set: assert property (
		grp_rise[0] |=> s_reg.gflag[0]
	) else $error("group flag missed a member rise");

	a_group_vec_cause: assert property (
		vector_call && vector_id == ims_pkg::VEC_GRP1
		|-> $past(s_reg.gen[1] && s_reg.gflag[1])
	) else $error("group vector without enabled group flag");

	a_entry_clears_gie: assert property (
		vector_call |-> !s_reg.gie && (vector_id != ims_pkg::VEC_GRP0
			|| !s_reg.gflag[0] || $past(grp_rise[0]))
	) else $error("global enable still set after entry");

	a_members_kept: assert property (
		vec_take && pend_g0 && !pend_ct0 && !pend_ptm && !avs_write
		|=> ((($past(flags) & ims_pkg::FLAGS_GRP0) & ~flags) == '0)
	) else $error("member flags lost on group service");

	a_own_flag_clear: assert property (
		vec_take && pend_ct0 && !avs_write && tm_match_a[0] == 1'b0
		&& tm_match_p[0] == 1'b0
		|=> (flags & s_reg.ten & ims_pkg::FLAGS_CT0) == '0
	) else $error("timer zero flag not cleared on entry");

	a_wake_on_rise: assert property (
		core.sleep_idle && |rises |=> wake_up
			&& s_reg.stat[ims_pkg::STAT_WAKE]
	) else $error("no wake-up on rising flag");

	a_flag_holds: assert property (
		1'b1 |=> ((($past(flags) & ~$past(flag_clr)) & ~flags) == '0)
	) else $error("flag dropped without a clear");

	a_exit_sets_gie: assert property (
		core.intr_exit && !vec_take |=> s_reg.gie
	) else $error("interrupt exit did not re-enable");

	a_ret_keeps_gie: assert property (
		core.sub_exit && !s_reg.gie && !core.intr_exit && !avs_write
		|=> !s_reg.gie
	) else $error("subroutine exit changed global enable");

	a_vec_gating: assert property (
		vector_call |-> $past(s_reg.gie) && $past(!full)
			&& $past(core.insn_boundary)
	) else $error("vector taken without enable, room or boundary");

	c_group_entry: cover property (
		vector_call && vector_id == ims_pkg::VEC_GRP0
	);
	c_own_entry: cover property (
		vector_call && vector_id == ims_pkg::VEC_PTM
	);
	c_wake: cover property (wake_up);
	c_full_block: cover property (
		core.insn_boundary && full && s_reg.gie && pend_ct0
	);
endmodule : ims_sequencer

/* File: dv/ims_core_model.sv */
`timescale 1ns/100ps
// Far-side core: boundary every fourth clock, exits and calls on command
module ims_core_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [1:0] cmd,
	input wire logic sleep_req,
	output ims_pkg::ims_core_t core
);
	logic [1:0] cyc_reg;

	// boundary pacing, commanded pushes only
	// No push on a vector call: the sequencer counts that entry itself
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cyc_reg <= 2'h0;
			core <= '0;
		end else begin
			cyc_reg <= cyc_reg + 2'h1;
			core.insn_boundary <= (cyc_reg == 2'h3);
			core.intr_exit <= (cmd == 2'h1);
			core.sub_exit <= (cmd == 2'h2);
			core.call_push <= (cmd == 2'h3);
			core.sleep_idle <= sleep_req;
		end
	end
endmodule : ims_core_model

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) cmp(32'(g), 32'(e))
module tb_top;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [4:0] tm_match_a = 5'h00;
	logic [4:0] tm_match_p = 5'h00;
	logic [1:0] cmd = 2'h0;
	logic sleep_req = 1'b0;
	ims_pkg::ims_core_t core;
	ims_pkg::ims_vec_t vector_id;
	logic vector_call;
	logic wake_up;
	logic stack_full;
	logic irq;
	int n_mismatch = 0;
	int n_checks = 0;
	int wake_cnt = 0;
	int seed = 32'h2B72;
	int i;
	int k;
	logic [31:0] exp_rd[$];
	logic [31:0] exp_vec[$];
	int bits[4] = '{3, 0, 6, 9};
	ims_pkg::ims_vec_t vecs[4] = '{ims_pkg::VEC_GRP0, ims_pkg::VEC_CT0,
		ims_pkg::VEC_GRP1, ims_pkg::VEC_PTM};

	// 50 MHz system clock
	always #10 sys_clk = ~sys_clk;

	ims_sequencer ims_sequencer_inst (
		.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tm_match_a(tm_match_a),
		.tm_match_p(tm_match_p), .core(core), .vector_call(vector_call),
		.vector_id(vector_id), .wake_up(wake_up),
		.stack_full(stack_full), .irq(irq));

	ims_core_model ims_core_model_inst (
		.sys_clk(sys_clk), .reset_n(reset_n), .cmd(cmd),
		.sleep_req(sleep_req), .core(core));

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim

	// One bus cycle, held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
			end_sim();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : idle

	// One-cycle match pulse on flag bit b: even is A, odd is P
	task automatic pulse(input int b);
		@(posedge sys_clk);
		tm_match_a[b / 2] <= 1'(!(b % 2));
		tm_match_p[b / 2] <= 1'(b % 2);
		@(posedge sys_clk);
		tm_match_a <= 5'h00;
		tm_match_p <= 5'h00;
	endtask : pulse

	task automatic act(input logic [1:0] c);
		@(posedge sys_clk);
		cmd <= c;
		@(posedge sys_clk);
		cmd <= 2'h0;
	endtask : act

	// Monitor: each completed read or vector call takes the oldest note
	always @(posedge sys_clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			`CHK(avs_readdata, exp_rd.pop_front());
		end
		if (vector_call === 1'b1) begin
			`CHK(vector_id, exp_vec.size() ? exp_vec.pop_front() : 32'hX);
		end
		if (wake_up === 1'b1) begin
			wake_cnt++;
		end
	end

	// Hang guard
	initial begin
		#2000000;
		n_mismatch++;
		end_sim();
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(ims_pkg::ADDR_CTRL, 32'h0);
		wr(8'h1C, $random(seed));
		rd(8'h1C, 32'h0);
		// Group flag sets but group enable is still clear
		wr(ims_pkg::ADDR_TEN, 32'h8);
		wr(ims_pkg::ADDR_CTRL, 32'h1);
		pulse(3);
		idle(12);
		rd(ims_pkg::ADDR_GFLAG, 32'h1);
		// Every vector once, A and P matches both used
		for (i = 0; i < 4; i++) begin
			k = bits[i];
			wr(ims_pkg::ADDR_TEN, 32'h1 << k);
			exp_vec.push_back(vecs[i]);
			wr(ims_pkg::ADDR_CTRL, 32'h7);
			pulse(k);
			idle(12);
			rd(ims_pkg::ADDR_CTRL, 32'h16);
			rd(ims_pkg::ADDR_TFLAG, (k == 3 || k == 6) ? 32'h1 << k : 32'h0);
			rd(ims_pkg::ADDR_GFLAG, 32'h0);
			wr(ims_pkg::ADDR_TFLAG, 32'h3FF);
			act(2'h1);
			rd(ims_pkg::ADDR_CTRL, 32'h7);
		end
		wr(ims_pkg::ADDR_TEN, 32'h1);
		exp_vec.push_back(ims_pkg::VEC_CT0);
		pulse(0);
		idle(12);
		act(2'h2);
		rd(ims_pkg::ADDR_CTRL, 32'h6);
		// Fill the stack, then a pending source must wait for a pop
		for (i = 0; i < 8; i++) begin
			act(2'h3);
		end
		idle(2);
		`CHK(stack_full, 1'b1);
		wr(ims_pkg::ADDR_CTRL, 32'h7);
		pulse(0);
		idle(12);
		exp_vec.push_back(ims_pkg::VEC_CT0);
		act(2'h2);
		idle(12);
		rd(ims_pkg::ADDR_CTRL, 32'h86);
		rd(ims_pkg::ADDR_STAT, 32'h1);
		// Wake: a flag set beforehand must not wake, global enable off
		wr(ims_pkg::ADDR_MASK, 32'h2);
		wr(ims_pkg::ADDR_TSET, 32'h200);
		idle(4);
		sleep_req <= 1'b1;
		pulse(9);
		idle(6);
		`CHK(wake_cnt, 0);
		`CHK(irq, 1'b0);
		pulse(8);
		idle(6);
		`CHK(wake_cnt, 1);
		`CHK(irq, 1'b1);
		rd(ims_pkg::ADDR_STAT, 32'h2);
		idle(1);
		`CHK(irq, 1'b0);
		sleep_req <= 1'b0;
		idle(4);
		`CHK(exp_vec.size(), 0);
		end_sim();
	end
endmodule : tb_top
